// >>> core/smpc_bank.sv
// two-copy banked register with secure and non-secure instances
`timescale 1ns/100ps
module smpc_bank #(
    parameter int unsigned WIDTH = smpc_pkg::SMPC_CTRL_W,
    parameter logic [WIDTH-1:0] RST_VAL = smpc_pkg::SMPC_CTRL_RST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic wr_ns,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic sel_ns,
    output logic [WIDTH-1:0] cur_val,
    output logic [WIDTH-1:0] s_val,
    output logic [WIDTH-1:0] ns_val
);
    logic [WIDTH-1:0] s_q;
    logic [WIDTH-1:0] s_d;
    logic [WIDTH-1:0] ns_q;
    logic [WIDTH-1:0] ns_d;

    always_comb begin
        s_d = s_q;
        ns_d = ns_q;
        if (wr_en && wr_ns) begin
            ns_d = wr_data;
        end else if (wr_en) begin
            s_d = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= RST_VAL;
            ns_q <= RST_VAL;
        end else if (ce) begin
            s_q <= s_d;
            ns_q <= ns_d;
        end
    end

    // copy chosen by the current security state
    assign cur_val = sel_ns ? ns_q : s_q;
    assign s_val = s_q;
    assign ns_val = ns_q;
endmodule : smpc_bank

// >>> core/smpc_ctrl.sv
// execution mode, privilege and security state tracking with apb register access
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - with the security option built, reset leaves the core in secure state.
// - thread or handler mode combines freely with secure or non-secure state.
// - banked registers keep secure and non-secure copies; current state selects one.
// - secure code may read the non-secure control copy too, and write it when privileged.
// - a per-interrupt bit picks the security state the interrupt is taken in.
// - non-secure execution is refused any access to secure memory.
// - reset leaves the core in thread mode.
// - exception return to non-exception code switches back to thread mode.
// - every exception entry puts the core in handler mode.
// - in thread mode the control register privilege bit decides privilege.
// - handler mode is always privileged whatever the control bit holds.
// - only privileged code may write the control register; others leave it.
// - the supervisor call instruction raises an exception into privileged handler code.
// - privileged code reaches all resources its security state allows; unprivileged code only unrestricted ones.
module smpc_ctrl #(
    parameter bit HAS_SEC = 1'b1,
    parameter int unsigned NUM_IRQ = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smpc_pkg::SMPC_ADDR_W-1:0] paddr,
    input wire logic [smpc_pkg::SMPC_DATA_W-1:0] pwdata,
    output logic [smpc_pkg::SMPC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire smpc_pkg::smpc_exc_s exc,
    input wire logic supervisor_call_instr,
    input wire smpc_pkg::smpc_acc_s acc,
    output logic handler_mode,
    output logic secure_state,
    output logic privileged,
    output logic call_taken,
    output logic acc_ok,
    output logic acc_fault
);
    smpc_pkg::smpc_mode_e mode_q;
    smpc_pkg::smpc_mode_e mode_d;
    logic sec_q;
    logic sec_d;
    logic priv_q;
    logic priv_d;
    logic call_q;
    logic call_d;
    logic acc_ok_q;
    logic acc_ok_d;
    logic acc_fault_q;
    logic acc_fault_d;
    logic [NUM_IRQ-1:0] irq_tgt_q;
    logic [NUM_IRQ-1:0] irq_tgt_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [smpc_pkg::SMPC_DATA_W-1:0] prdata_q;
    logic [smpc_pkg::SMPC_DATA_W-1:0] prdata_d;

    logic [smpc_pkg::SMPC_CTRL_W-1:0] ctrl_cur;
    logic [smpc_pkg::SMPC_CTRL_W-1:0] ctrl_s;
    logic [smpc_pkg::SMPC_CTRL_W-1:0] ctrl_ns;
    logic ctrl_wr_en;
    logic ctrl_wr_ns;
    logic priv_now;
    logic entry_any;
    logic irq_ns_sel;
    logic apb_probe;
    logic apb_commit;
    smpc_pkg::smpc_sel_e sel;

    // register select from the bus address
    function automatic smpc_pkg::smpc_sel_e smpc_decode(
        input logic [smpc_pkg::SMPC_ADDR_W-1:0] addr
    );
        smpc_pkg::smpc_sel_e s;
        case (addr)
            smpc_pkg::SMPC_OFF_STATUS: s = smpc_pkg::SMPC_SEL_STATUS;
            smpc_pkg::SMPC_OFF_CTRL: s = smpc_pkg::SMPC_SEL_CTRL;
            smpc_pkg::SMPC_OFF_CTRL_NS: s = smpc_pkg::SMPC_SEL_CTRL_NS;
            smpc_pkg::SMPC_OFF_IRQ_TGT: s = smpc_pkg::SMPC_SEL_IRQ_TGT;
            default: s = smpc_pkg::SMPC_SEL_NONE;
        endcase
        return s;
    endfunction : smpc_decode

    assign sel = smpc_decode(paddr);
    assign apb_probe = psel && penable && !pready_q;
    // write lands only at the edge that sees pready high
    assign apb_commit = psel && penable && pready_q && pwrite && !pslverr_q;

    // handler ignores the thread privilege bit of the selected copy
    assign priv_now = (mode_q == smpc_pkg::SMPC_HANDLER) ||
                      !ctrl_cur[smpc_pkg::SMPC_CTRL_NPRIV_BIT];

    // supervisor call is folded into exception entry
    assign entry_any = exc.entry || supervisor_call_instr;
    assign irq_ns_sel = irq_tgt_q[exc.irq_num];

    // control writes need privilege; ns alias needs secure state
    always_comb begin
        ctrl_wr_en = 1'b0;
        ctrl_wr_ns = !sec_q;
        if (apb_commit && priv_now) begin
            if (sel == smpc_pkg::SMPC_SEL_CTRL) begin
                ctrl_wr_en = 1'b1;
                ctrl_wr_ns = !sec_q;
            end else if (sel == smpc_pkg::SMPC_SEL_CTRL_NS && sec_q) begin
                ctrl_wr_en = 1'b1;
                ctrl_wr_ns = 1'b1;
            end
        end
    end

    smpc_bank #(
        .WIDTH(smpc_pkg::SMPC_CTRL_W),
        .RST_VAL(smpc_pkg::SMPC_CTRL_RST)
    ) u_ctrl_bank (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_en(ctrl_wr_en),
        .wr_ns(ctrl_wr_ns),
        .wr_data(pwdata[smpc_pkg::SMPC_CTRL_W-1:0]),
        .sel_ns(!sec_q),
        .cur_val(ctrl_cur),
        .s_val(ctrl_s),
        .ns_val(ctrl_ns)
    );

    // mode and security state; entry wins over a same-cycle return
    always_comb begin
        mode_d = mode_q;
        sec_d = sec_q;
        if (entry_any) begin
            mode_d = smpc_pkg::SMPC_HANDLER;
            if (exc.entry && exc.is_irq && !supervisor_call_instr) begin
                sec_d = HAS_SEC && !irq_ns_sel;
            end
        end else if (exc.ret) begin
            if (exc.ret_thread) begin
                mode_d = smpc_pkg::SMPC_THREAD;
            end
            sec_d = HAS_SEC && exc.ret_secure;
        end
    end

    // access checks: security first, then privilege
    always_comb begin
        priv_d = priv_now;
        call_d = supervisor_call_instr;
        acc_ok_d = 1'b0;
        acc_fault_d = 1'b0;
        if (acc.req) begin
            if (acc.region_secure && !sec_q) begin
                acc_fault_d = 1'b1;
            end else if (acc.priv_only && !priv_now) begin
                acc_fault_d = 1'b1;
            end else begin
                acc_ok_d = 1'b1;
            end
        end
    end

    // apb slave: one wait state, response registered
    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        irq_tgt_d = irq_tgt_q;
        if (apb_probe) begin
            pready_d = 1'b1;
            prdata_d = smpc_pkg::SMPC_ZERO_WORD;
            case (sel)
                smpc_pkg::SMPC_SEL_STATUS: begin
                    prdata_d[smpc_pkg::SMPC_STAT_HANDLER_BIT] = (mode_q == smpc_pkg::SMPC_HANDLER);
                    prdata_d[smpc_pkg::SMPC_STAT_SECURE_BIT] = sec_q;
                    prdata_d[smpc_pkg::SMPC_STAT_PRIV_BIT] = priv_now;
                    pslverr_d = pwrite;
                end
                smpc_pkg::SMPC_SEL_CTRL: begin
                    prdata_d[smpc_pkg::SMPC_CTRL_W-1:0] = ctrl_cur;
                end
                smpc_pkg::SMPC_SEL_CTRL_NS: begin
                    // the alias is invisible from non-secure state
                    if (sec_q) begin
                        prdata_d[smpc_pkg::SMPC_CTRL_W-1:0] = ctrl_ns;
                    end else begin
                        pslverr_d = 1'b1;
                    end
                end
                smpc_pkg::SMPC_SEL_IRQ_TGT: begin
                    if (sec_q) begin
                        prdata_d[NUM_IRQ-1:0] = irq_tgt_q;
                    end
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (apb_commit && sel == smpc_pkg::SMPC_SEL_IRQ_TGT && sec_q && priv_now) begin
            irq_tgt_d = pwdata[NUM_IRQ-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= smpc_pkg::SMPC_THREAD;
            sec_q <= HAS_SEC;
            priv_q <= 1'b1;
            call_q <= 1'b0;
            acc_ok_q <= 1'b0;
            acc_fault_q <= 1'b0;
            irq_tgt_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= smpc_pkg::SMPC_ZERO_WORD;
        end else if (ce) begin
            mode_q <= mode_d;
            sec_q <= sec_d;
            priv_q <= priv_d;
            call_q <= call_d;
            acc_ok_q <= acc_ok_d;
            acc_fault_q <= acc_fault_d;
            irq_tgt_q <= irq_tgt_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign handler_mode = (mode_q == smpc_pkg::SMPC_HANDLER);
    assign secure_state = sec_q;
    assign privileged = priv_q;
    assign call_taken = call_q;
    assign acc_ok = acc_ok_q;
    assign acc_fault = acc_fault_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence call_in;
        ce && supervisor_call_instr;
    endsequence
    sequence call_out;
        call_taken && handler_mode;
    endsequence

    reset_secure_a: assert property (disable iff (1'b0) rst |=> sec_q == HAS_SEC)
        else $error("reset did not give the built security state");
    reset_thread_a: assert property (disable iff (1'b0) rst |=> !handler_mode)
        else $error("reset did not give thread mode");
    entry_handler_a: assert property (ce && entry_any |=> handler_mode)
        else $error("exception entry missed handler mode");
    ret_thread_a: assert property (ce && !entry_any && exc.ret && exc.ret_thread
        |=> !handler_mode)
        else $error("return to thread kept handler mode");
    irq_target_a: assert property (ce && exc.entry && exc.is_irq
        && !supervisor_call_instr |=> sec_q == (HAS_SEC && !$past(irq_ns_sel)))
        else $error("interrupt taken in wrong security state");
    handler_priv_a: assert property (ce && handler_mode |=> privileged)
        else $error("handler mode reported unprivileged");
    thread_priv_a: assert property (ce && !handler_mode
        |=> privileged == !$past(ctrl_cur[smpc_pkg::SMPC_CTRL_NPRIV_BIT]))
        else $error("thread privilege not taken from control bit");
    unpriv_ctrl_a: assert property (ce && apb_commit && !priv_now
        |=> ctrl_s == $past(ctrl_s) && ctrl_ns == $past(ctrl_ns))
        else $error("unprivileged write changed control");
    call_entry_a: assert property (call_in |=> call_out)
        else $error("supervisor call did not enter handler");
    ns_block_a: assert property (ce && acc.req && acc.region_secure && !sec_q
        |=> acc_fault && !acc_ok)
        else $error("non-secure access to secure memory passed");
    unpriv_res_a: assert property (ce && acc.req && acc.priv_only && !priv_now
        |=> acc_fault)
        else $error("unprivileged access to restricted resource passed");
    ns_alias_a: assert property (ce && apb_probe && !pwrite
        && sel == smpc_pkg::SMPC_SEL_CTRL_NS && sec_q |=> pready && !pslverr
        && prdata[smpc_pkg::SMPC_CTRL_W-1:0] == $past(ctrl_ns))
        else $error("secure read of non-secure control copy wrong");
    bank_sel_a: assert property (ce && apb_probe && !pwrite
        && sel == smpc_pkg::SMPC_SEL_CTRL
        |=> prdata[smpc_pkg::SMPC_CTRL_W-1:0] == $past(ctrl_cur))
        else $error("control read returned wrong bank");
    // a lost or doubled check answer would stall or confuse the load unit
    acc_answer_a: assert property (ce && acc.req |=> acc_ok != acc_fault)
        else $error("access check gave no single answer");
    call_sec_a: assert property (ce && supervisor_call_instr
        |=> secure_state == $past(sec_q))
        else $error("supervisor call changed security state");
    ret_state_a: assert property (ce && !entry_any && exc.ret
        |=> secure_state == (HAS_SEC && $past(exc.ret_secure)))
        else $error("return gave wrong security state");
endmodule : smpc_ctrl

// >>> core/smpc_pkg.sv
// shared constants, types and register map of the execution context controller
package smpc_pkg;
    localparam int unsigned SMPC_ADDR_W = 8;
    localparam int unsigned SMPC_DATA_W = 32;
    localparam int unsigned SMPC_IRQ_NUM_W = 5;
    localparam int unsigned SMPC_CTRL_W = 2;

    // register byte offsets
    localparam logic [SMPC_ADDR_W-1:0] SMPC_OFF_STATUS = 8'h00;
    localparam logic [SMPC_ADDR_W-1:0] SMPC_OFF_CTRL = 8'h04;
    localparam logic [SMPC_ADDR_W-1:0] SMPC_OFF_CTRL_NS = 8'h08;
    localparam logic [SMPC_ADDR_W-1:0] SMPC_OFF_IRQ_TGT = 8'h0c;

    // control register fields
    localparam int unsigned SMPC_CTRL_NPRIV_BIT = 0;
    localparam int unsigned SMPC_CTRL_SPSEL_BIT = 1;
    localparam logic [SMPC_CTRL_W-1:0] SMPC_CTRL_RST = 2'h0;

    // status register fields
    localparam int unsigned SMPC_STAT_HANDLER_BIT = 0;
    localparam int unsigned SMPC_STAT_SECURE_BIT = 1;
    localparam int unsigned SMPC_STAT_PRIV_BIT = 2;

    localparam logic [SMPC_DATA_W-1:0] SMPC_ZERO_WORD = 32'h0000_0000;

    // register select codes
    typedef enum logic [2:0] {
        SMPC_SEL_NONE = 3'h0,
        SMPC_SEL_STATUS = 3'h1,
        SMPC_SEL_CTRL = 3'h2,
        SMPC_SEL_CTRL_NS = 3'h3,
        SMPC_SEL_IRQ_TGT = 3'h4
    } smpc_sel_e;

    typedef enum logic [0:0] {
        SMPC_THREAD = 1'b0,
        SMPC_HANDLER = 1'b1
    } smpc_mode_e;

    // exception event from the core pipeline
    typedef struct packed {
        logic entry;
        logic is_irq;
        logic [SMPC_IRQ_NUM_W-1:0] irq_num;
        logic ret;
        logic ret_thread;
        logic ret_secure;
    } smpc_exc_s;

    // memory or resource access check request
    typedef struct packed {
        logic req;
        logic region_secure;
        logic priv_only;
    } smpc_acc_s;
endpackage : smpc_pkg

// >>> tb/test_smpc_ctrl.sv
// self-checking testbench for the execution context controller
`timescale 1ns/100ps
module test_smpc_ctrl;
    logic clk;
    logic rst;
    logic ce;
    logic psel;
    logic penable;
    logic pwrite;
    logic [smpc_pkg::SMPC_ADDR_W-1:0] paddr;
    logic [smpc_pkg::SMPC_DATA_W-1:0] pwdata;
    logic [smpc_pkg::SMPC_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    smpc_pkg::smpc_exc_s exc;
    logic supervisor_call_instr;
    smpc_pkg::smpc_acc_s acc;
    logic handler_mode;
    logic secure_state;
    logic privileged;
    logic call_taken;
    logic acc_ok;
    logic acc_fault;
    int failures;
    int n_compared;
    logic [31:0] rd;
    logic er;

    smpc_ctrl #(.HAS_SEC(1'b1), .NUM_IRQ(32)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exc(exc), .supervisor_call_instr(supervisor_call_instr), .acc(acc),
        .handler_mode(handler_mode), .secure_state(secure_state), .privileged(privileged),
        .call_taken(call_taken), .acc_ok(acc_ok), .acc_fault(acc_fault)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, x);
        end
    endtask : chk

    // master holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [smpc_pkg::SMPC_ADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: no answer on the register bus", $time);
            stop_test();
        end else begin
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [smpc_pkg::SMPC_ADDR_W-1:0] a, input logic [31:0] d,
                      input logic ee);
        apb(1'b1, a, d, rd, er);
        chk({31'h0, er}, {31'h0, ee});
    endtask : wr

    task automatic rdc(input logic [smpc_pkg::SMPC_ADDR_W-1:0] a, input logic [31:0] x,
                       input logic ee);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, x);
        chk({31'h0, er}, {31'h0, ee});
    endtask : rdc

    // status bits: privileged, secure, handler
    task automatic st(input logic [2:0] x);
        rdc(smpc_pkg::SMPC_OFF_STATUS, {29'h0, x}, 1'b0);
    endtask : st

    // extra cycles let the registered privilege catch up
    task automatic exc_ev(input logic en, input logic [4:0] n, input logic rs);
        smpc_pkg::smpc_exc_s e;
        e = '0;
        e.entry = en;
        e.is_irq = en;
        e.irq_num = n;
        e.ret = ~en;
        e.ret_thread = ~en;
        e.ret_secure = rs;
        @(posedge clk);
        exc <= e;
        @(posedge clk);
        exc <= '0;
        repeat (2) @(posedge clk);
    endtask : exc_ev

    task automatic acc_try(input logic rs, input logic po, input logic [1:0] x);
        @(posedge clk);
        acc <= '{req: 1'b1, region_secure: rs, priv_only: po};
        @(posedge clk);
        acc <= '0;
        #1;
        chk({30'h0, acc_ok, acc_fault}, {30'h0, x});
    endtask : acc_try

    initial begin
        failures = 0;
        n_compared = 0;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        exc = '0;
        supervisor_call_instr = 1'b0;
        acc = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        st(3'h6);
        wr(smpc_pkg::SMPC_OFF_CTRL, 32'h1, 1'b0);
        st(3'h2);
        // unprivileged write is dropped silently
        wr(smpc_pkg::SMPC_OFF_CTRL, 32'h0, 1'b0);
        rdc(smpc_pkg::SMPC_OFF_CTRL, 32'h1, 1'b0);
        acc_try(1'b0, 1'b1, 2'h1);
        acc_try(1'b1, 1'b0, 2'h2);
        @(posedge clk);
        supervisor_call_instr <= 1'b1;
        @(posedge clk);
        supervisor_call_instr <= 1'b0;
        #1;
        chk({30'h0, call_taken, handler_mode}, 32'h3);
        @(posedge clk);
        #1;
        chk({30'h0, privileged, call_taken}, 32'h2);
        st(3'h7);
        wr(smpc_pkg::SMPC_OFF_CTRL_NS, 32'h1, 1'b0);
        rdc(smpc_pkg::SMPC_OFF_CTRL_NS, 32'h1, 1'b0);
        wr(smpc_pkg::SMPC_OFF_IRQ_TGT, 32'h8, 1'b0);
        rdc(smpc_pkg::SMPC_OFF_IRQ_TGT, 32'h8, 1'b0);
        acc_try(1'b0, 1'b1, 2'h2);
        exc_ev(1'b0, 5'h0, 1'b1);
        st(3'h2);
        exc_ev(1'b1, 5'h3, 1'b0);
        st(3'h5);
        rdc(smpc_pkg::SMPC_OFF_CTRL, 32'h1, 1'b0);
        rdc(smpc_pkg::SMPC_OFF_CTRL_NS, 32'h0, 1'b1);
        acc_try(1'b1, 1'b0, 2'h1);
        wr(smpc_pkg::SMPC_OFF_CTRL, 32'h0, 1'b0);
        rdc(smpc_pkg::SMPC_OFF_CTRL, 32'h0, 1'b0);
        exc_ev(1'b0, 5'h0, 1'b0);
        st(3'h4);
        exc_ev(1'b1, 5'h0, 1'b0);
        st(3'h7);
        rdc(smpc_pkg::SMPC_OFF_CTRL, 32'h1, 1'b0);
        rdc(8'h10, 32'h0, 1'b1);
        wr(smpc_pkg::SMPC_OFF_STATUS, 32'h0, 1'b1);
        exc_ev(1'b0, 5'h0, 1'b1);
        st(3'h2);
        // a call pulse while the enable is low must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        supervisor_call_instr <= 1'b1;
        @(posedge clk);
        supervisor_call_instr <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        #1;
        chk({30'h0, call_taken, handler_mode}, 32'h0);
        st(3'h2);
        exc_ev(1'b1, 5'h3, 1'b0);
        #1;
        chk({31'h0, secure_state}, 32'h0);
        // reset again from non-secure handler with state stored
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        st(3'h6);
        chk({31'h0, secure_state}, 32'h1);
        rdc(smpc_pkg::SMPC_OFF_CTRL, 32'h0, 1'b0);
        rdc(smpc_pkg::SMPC_OFF_IRQ_TGT, 32'h0, 1'b0);
        stop_test();
    end
endmodule : test_smpc_ctrl
